// *** timer_edge_capture.v ***
// 16-bit free-running timebase with two edge-capture channels and an
// APB register slave; tick and wrap interrupts plus capture interrupts.
// assumes one core clock; the capture clock is an enable from a divider
// and the two edge inputs arrive asynchronously from pins.
//
// Behaviour
// RQ1 - counter of 16 bits advances once per capture clock tick
// RQ2 - low byte read returns live value and latches high byte for later
// RQ3 - low byte write is buffered; high byte write loads all 16 bits
// RQ4 - software accesses low byte first, then high byte
// RQ5 - periodic tick event every 4096 counts, 1024 us at 4 MHz
// RQ6 - wrap event whenever the 16-bit counter overflows
// RQ7 - two channels, each with rise and fall capture registers
// RQ8 - without first-edge-hold every edge overwrites its capture register
// RQ9 - with first-edge-hold a register keeps first edge until read
// RQ10 - prescale n selects counter bits [7+n:n] for 8-bit capture
// RQ11 - wide enable stops channel 1 and uses its registers for channel 0
// RQ12 - wide mode: channel 0 holds bits 7:0, channel 1 bits 15:8
// RQ13 - one interrupt enable per capture register, bits 0 to 3
// RQ14 - load sets status flag; writing one clears, zero leaves it
// RQ15 - software clears a handled capture flag by writing one
// RQ16 - flag bits: 0 ch0 rise, 1 ch0 fall, 2 ch1 rise, 3 ch1 fall
// RQ17 - timer runs from its own capture clock, apart from bus timing
// RQ18 - tick, channel 0, channel 1 and wrap requests leave separately
// RQ19 - inputs synchronised; reserved bits read zero; capture writes ignored
`timescale 1ns/1ps
`include "timer_edge_capture_consts.vh"

module timer_edge_capture #(
  parameter CORE_CLK_HZ = `TEC_CORE_CLK_HZ,
  parameter CAPTURE_HZ = `TEC_CAPTURE_HZ
) (
  // clock and reset
  input wire CORE_CLK,
  input wire SRST,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [9:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // edge inputs from pins
  input wire EDGE_INPUT_A,
  input wire EDGE_INPUT_B,
  // interrupt requests
  output reg IRQ_TICK,
  output reg IRQ_CAP0,
  output reg IRQ_CAP1,
  output reg IRQ_WRAP,
  output reg IRQ
);

  // divider and tick figures derived from the clock rates
  // integer figures are cut to the 16-bit counter width on purpose
  localparam integer DIV = CORE_CLK_HZ / CAPTURE_HZ;
  localparam integer DIV_LAST_FULL = DIV - 1;
  localparam [15:0] DIV_LAST = DIV_LAST_FULL[15:0];
  localparam integer TICK_COUNTS =
    `TEC_TICK_PERIOD_US * (CAPTURE_HZ / 1_000_000);
  localparam integer TICK_MASK_FULL = TICK_COUNTS - 1;
  localparam [15:0] TICK_MASK = TICK_MASK_FULL[15:0];

  // true when the byte address selects the given register index
  function hit;
    input [9:0] addr;
    input [7:0] idx;
    begin
      hit = (addr[1:0] == 2'b00) && (addr[9:2] == idx);
    end
  endfunction

  // eight-bit window [7+n:n] of the counter
  function [7:0] window;
    input [15:0] cnt;
    input [2:0] n;
    reg [15:0] sh;
    begin
      sh = cnt >> n;
      window = sh[7:0];
    end
  endfunction

  // capture clock divider
  reg [15:0] div_cnt;
  reg cap_tick;

  // counter and its byte-wise access latches
  reg [15:0] count;
  reg [7:0] low_buf;
  reg [7:0] high_hold;

  // configuration and capture interrupt state
  reg hold_first;
  reg [2:0] prescale;
  reg wide;
  reg [3:0] irq_en;
  reg [3:0] cap_flags;

  // capture registers and their first-edge locks
  reg [3:0] lock;
  reg [7:0] cap_val [0:3];

  // timebase and load events for the summary interrupt
  reg [3:0] evt_status;
  reg [3:0] evt_mask;

  // pin synchronisers and filtered levels
  reg [2:0] sync_a;
  reg [2:0] sync_b;
  reg lvl_a;
  reg lvl_b;

  // combinational read path and capture decode
  reg [31:0] next_rdata;
  reg next_err;
  reg [3:0] cap_evt;
  reg [3:0] load;
  reg [7:0] cap_new [0:3];

  // one loop index per process, so each has a single driver
  integer k;
  integer i;

  // the timebase advances only on this pulse, so captures and events
  // keep the pace of the capture clock whatever the bus does
  // one-cycle capture clock enable from the core clock [RQ17]
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      div_cnt <= 16'h0000;
      cap_tick <= 1'b0;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= 16'h0000;
      cap_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      cap_tick <= 1'b0;
    end
  end

  // the first stage may go metastable; only the second stage reads it,
  // and a glitch that stages 2 and 3 never agree on is dropped
  // three-stage pin synchronisers; level moves when stages 2 and 3 agree
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      sync_a <= 3'b000;
      sync_b <= 3'b000;
      lvl_a <= 1'b0;
      lvl_b <= 1'b0;
    end else begin
      sync_a <= {sync_a[1:0], EDGE_INPUT_A}; // [RQ19]
      sync_b <= {sync_b[1:0], EDGE_INPUT_B}; // [RQ19]
      if (sync_a[1] == sync_a[2]) begin
        lvl_a <= sync_a[2];
      end
      if (sync_b[1] == sync_b[2]) begin
        lvl_b <= sync_b[2];
      end
    end
  end

  // edges of the filtered levels
  wire agree_a = (sync_a[1] == sync_a[2]);
  wire agree_b = (sync_b[1] == sync_b[2]);
  wire rise_a = agree_a & sync_a[2] & ~lvl_a;
  wire fall_a = agree_a & ~sync_a[2] & lvl_a;
  wire rise_b = agree_b & sync_b[2] & ~lvl_b;
  wire fall_b = agree_b & ~sync_b[2] & lvl_b;

  // decoding on the first access cycle only keeps read-clear and the
  // low-byte latch from firing again while pready stands
  // apb access decode; side effects happen once, at the wait cycle
  wire acc = PSEL & PENABLE & ~PREADY;
  wire wr = acc & PWRITE & PSTRB[0];
  wire rd = acc & ~PWRITE;
  wire [7:0] wd = PWDATA[7:0];
  wire h_lo = hit(PADDR, `TEC_IDX_COUNT_LOW);
  wire h_hi = hit(PADDR, `TEC_IDX_COUNT_HIGH);
  wire h_c0r = hit(PADDR, `TEC_IDX_CH0_RISE);
  wire h_c1r = hit(PADDR, `TEC_IDX_CH1_RISE);
  wire h_c0f = hit(PADDR, `TEC_IDX_CH0_FALL);
  wire h_c1f = hit(PADDR, `TEC_IDX_CH1_FALL);
  wire h_cfg = hit(PADDR, `TEC_IDX_CONFIG);
  wire h_ien = hit(PADDR, `TEC_IDX_IRQ_ENABLE);
  wire h_flg = hit(PADDR, `TEC_IDX_IRQ_FLAGS);
  wire h_est = hit(PADDR, `TEC_IDX_EVT_STATUS);
  wire h_emk = hit(PADDR, `TEC_IDX_EVT_MASK);
  wire [3:0] rd_cap = {rd & h_c1f, rd & h_c1r, rd & h_c0f, rd & h_c0r};
  wire load_count = wr & h_hi;

  // the tick fires as the masked low bits roll over, the wrap as all
  // sixteen do; both can fall on the same capture tick
  // timebase events; a software load of the counter suppresses them
  wire tick_evt = cap_tick & ~load_count &
    ((count & TICK_MASK) == TICK_MASK); // [RQ5]
  wire wrap_evt = cap_tick & ~load_count &
    (count == 16'hffff); // [RQ6]

  // software must read low then high and write low then high; the
  // high byte write alone loads the counter with the last buffered low byte
  // free-running counter with coherent byte-wise load
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      count <= `TEC_RST_COUNT;
      low_buf <= `TEC_RST_BYTE;
      high_hold <= `TEC_RST_BYTE;
    end else begin
      if (load_count) begin
        count <= {wd, low_buf}; // [RQ3]
      end else if (cap_tick) begin
        count <= count + 16'h0001; // [RQ1]
      end
      if (wr & h_lo) begin
        low_buf <= wd; // [RQ3]
      end
      if (rd & h_lo) begin
        high_hold <= count[15:8]; // [RQ2]
      end
    end
  end

  // in wide mode channel 1's pin is ignored and its registers follow
  // the channel 0 edges with the counter's high byte
  // capture events, values and loads for the four registers
  always @* begin
    cap_evt[0] = rise_a; // [RQ7]
    cap_evt[1] = fall_a; // [RQ7]
    cap_evt[2] = wide ? rise_a : rise_b; // [RQ11]
    cap_evt[3] = wide ? fall_a : fall_b; // [RQ11]
    for (k = 0; k < 4; k = k + 1) begin
      if (wide) begin
        cap_new[k] = (k < 2) ? count[7:0] : count[15:8]; // [RQ12]
      end else begin
        cap_new[k] = window(count, prescale); // [RQ10]
      end
      load[k] = cap_evt[k] & ~(hold_first & lock[k]); // [RQ8] [RQ9]
    end
  end

  // capture registers and first-edge locks
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      for (i = 0; i < 4; i = i + 1) begin
        cap_val[i] <= `TEC_RST_BYTE;
      end
      lock <= `TEC_RST_NIBBLE;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (load[i]) begin
          cap_val[i] <= cap_new[i]; // [RQ8]
        end
      end
      // a fresh load wins over the read that releases the lock;
      // locks drop while hold is off, so turning hold on starts clean
      if (hold_first) begin
        lock <= (lock & ~rd_cap) | load; // [RQ9]
      end else begin
        lock <= `TEC_RST_NIBBLE;
      end
    end
  end

  // prescale, hold and wide take effect from the next edge on
  // configuration, enables and masks
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      hold_first <= 1'b0;
      prescale <= 3'b000;
      wide <= 1'b0;
      irq_en <= `TEC_RST_NIBBLE;
      evt_mask <= `TEC_RST_NIBBLE;
    end else begin
      if (wr & h_cfg) begin
        hold_first <= wd[`TEC_CFG_HOLD_BIT]; // [RQ9]
        prescale <= wd[`TEC_CFG_PRESCALE_HI:`TEC_CFG_PRESCALE_LO];
        wide <= wd[`TEC_CFG_WIDE_BIT]; // [RQ11]
      end
      if (wr & h_ien) begin
        irq_en <= wd[3:0]; // [RQ13]
      end
      if (wr & h_emk) begin
        evt_mask <= wd[3:0];
      end
    end
  end

  // evt_status bits 2 and 3 track any load of a channel's registers
  // status flags: write one to clear capture flags, read clears events;
  // a set in the same cycle wins over the clear
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      cap_flags <= `TEC_RST_NIBBLE;
      evt_status <= `TEC_RST_NIBBLE;
    end else begin
      cap_flags <= (cap_flags & ~({4{wr & h_flg}} & wd[3:0])) |
        load; // [RQ14] [RQ16]
      evt_status <= (evt_status & ~{4{rd & h_est}}) |
        {|load[3:2], |load[1:0], wrap_evt, tick_evt};
    end
  end

  // spare bits read as zero; capture registers have no write path, so
  // a write to them answers without error and changes nothing
  // read data and error for the addressed register
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (h_lo) begin
      next_rdata[7:0] = count[7:0]; // [RQ2]
    end else if (h_hi) begin
      next_rdata[7:0] = high_hold; // [RQ2]
    end else if (h_c0r) begin
      next_rdata[7:0] = cap_val[0];
    end else if (h_c1r) begin
      next_rdata[7:0] = cap_val[2];
    end else if (h_c0f) begin
      next_rdata[7:0] = cap_val[1];
    end else if (h_c1f) begin
      next_rdata[7:0] = cap_val[3];
    end else if (h_cfg) begin
      next_rdata[7:0] = {hold_first, prescale, wide, 3'b000}; // [RQ19]
    end else if (h_ien) begin
      next_rdata[3:0] = irq_en;
    end else if (h_flg) begin
      next_rdata[3:0] = cap_flags; // [RQ16]
    end else if (h_est) begin
      next_rdata[3:0] = evt_status;
    end else if (h_emk) begin
      next_rdata[3:0] = evt_mask;
    end else begin
      next_err = 1'b1;
    end
  end

  // pready, prdata and pslverr stand for exactly one cycle
  // apb answer: one wait cycle, then pready with registered data
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (acc) begin
      PREADY <= 1'b1;
      PRDATA <= PWRITE ? 32'h0000_0000 : next_rdata;
      PSLVERR <= next_err;
    end else begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
  end

  // each request is a level; it drops one cycle after its source clears
  // separate interrupt requests and the summary line
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      IRQ_TICK <= 1'b0;
      IRQ_CAP0 <= 1'b0;
      IRQ_CAP1 <= 1'b0;
      IRQ_WRAP <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      IRQ_TICK <= evt_status[`TEC_EVT_TICK] &
        evt_mask[`TEC_EVT_TICK]; // [RQ18]
      IRQ_WRAP <= evt_status[`TEC_EVT_WRAP] &
        evt_mask[`TEC_EVT_WRAP]; // [RQ18]
      IRQ_CAP0 <= |(cap_flags[1:0] & irq_en[1:0]); // [RQ13] [RQ18]
      IRQ_CAP1 <= |(cap_flags[3:2] & irq_en[3:2]); // [RQ13] [RQ18]
      IRQ <= |(evt_status & evt_mask);
    end
  end

endmodule

// *** timer_edge_capture_consts.vh ***
// constants for the free-running timer and edge capture block
// assumes an APB slave with one 32-bit word per byte register
`ifndef TIMER_EDGE_CAPTURE_CONSTS_VH
`define TIMER_EDGE_CAPTURE_CONSTS_VH

// register indices; byte address is four times the index
`define TEC_IDX_COUNT_LOW 8'h20
`define TEC_IDX_COUNT_HIGH 8'h21
`define TEC_IDX_CH0_RISE 8'h22
`define TEC_IDX_CH1_RISE 8'h23
`define TEC_IDX_CH0_FALL 8'h24
`define TEC_IDX_CH1_FALL 8'h25
`define TEC_IDX_CONFIG 8'h2a
`define TEC_IDX_IRQ_ENABLE 8'h2b
`define TEC_IDX_IRQ_FLAGS 8'h2c
`define TEC_IDX_EVT_STATUS 8'h2d
`define TEC_IDX_EVT_MASK 8'h2e

// configuration field positions
`define TEC_CFG_HOLD_BIT 7
`define TEC_CFG_PRESCALE_HI 6
`define TEC_CFG_PRESCALE_LO 4
`define TEC_CFG_WIDE_BIT 3

// event status and mask bit positions
`define TEC_EVT_TICK 0
`define TEC_EVT_WRAP 1
`define TEC_EVT_CAP0 2
`define TEC_EVT_CAP1 3

// reset values
`define TEC_RST_COUNT 16'h0000
`define TEC_RST_BYTE 8'h00
`define TEC_RST_NIBBLE 4'h0

// timing figures
`define TEC_CORE_CLK_HZ 40_000_000
`define TEC_CAPTURE_HZ 4_000_000
`define TEC_TICK_PERIOD_US 1024

`endif

// *** edge_src.sv ***
// partner: two edge sources driving the capture pins
// assumes the bench calls pulse from its main process
`timescale 1ns/1ps
module edge_src (
  // clock
  input wire clk,
  // pins
  output logic a,
  output logic b
);
  // both pins idle low
  initial begin
    a = 1'b0;
    b = 1'b0;
  end
  // rise, hold 8 clocks, fall, hold 8; outlasts the pin synchroniser
  task pulse(input int ch);
    @(posedge clk);
    {b, a} <= ch ? 2'b10 : 2'b01;
    repeat (8) @(posedge clk);
    {b, a} <= 2'b00;
    repeat (8) @(posedge clk);
  endtask
endmodule

// *** tec_sva.sv ***
// checker for the timer capture block, ports only
// assumes one clock domain and a bind to the top module
`timescale 1ns/1ps
module tec_sva (
  // clock and reset
  input wire CORE_CLK,
  input wire SRST,
  // apb
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [9:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  // interrupts
  input wire IRQ_TICK,
  input wire IRQ_CAP0,
  input wire IRQ_CAP1,
  input wire IRQ_WRAP,
  input wire IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  // request taken, and read answer present
  wire take = PSEL && PENABLE && !PREADY;
  wire rd_at = PREADY && !PWRITE;
  wire clr = take && PWRITE && PADDR == 10'h0B0 && PSTRB[0];
  property p_wait; take |=> PREADY; endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_err; PSLVERR |-> PREADY && PRDATA == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("bad error reply");
  property p_cfg; rd_at && PADDR == 10'h0A8 |-> !(|PRDATA[2:0]); endproperty
  a_cfg: assert property (p_cfg) else $error("config spare bits");
  property p_flg; rd_at && PADDR == 10'h0B0 |-> !(|PRDATA[31:4]); endproperty
  a_flg: assert property (p_flg) else $error("flag spare bits");
  property p_or; IRQ_TICK || IRQ_WRAP |-> IRQ; endproperty
  a_or: assert property (p_or) else $error("summary irq low");
  property p_clr; clr && PWDATA[3:0] == 4'hF |=> ##1 !IRQ_CAP0 && !IRQ_CAP1;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  property p_wrap; IRQ_WRAP && !PSEL |=> IRQ_WRAP; endproperty
  a_wrap: assert property (p_wrap) else $error("wrap irq lost");
  property p_cap; IRQ_CAP0 && !PSEL |=> IRQ_CAP0; endproperty
  a_cap: assert property (p_cap) else $error("capture irq lost");
  c_err: cover property (PSLVERR);
  c_wrap: cover property (IRQ_WRAP);
  c_clr: cover property (clr);
endmodule
bind timer_edge_capture tec_sva u_tec_sva (.CORE_CLK, .SRST, .PSEL,
  .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR,
  .IRQ_TICK, .IRQ_CAP0, .IRQ_CAP1, .IRQ_WRAP, .IRQ);

// *** testbench.sv ***
// self-checking bench for the timer capture block
// assumes default 4 MHz capture enable: one count per 10 clocks
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [9:0] pa = 10'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [3:0] pst = 4'h0;
  logic [31:0] r;
  logic e;
  wire [31:0] prd;
  wire prdy, perr, ea, eb;
  wire [4:0] irq;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int cap[4] = '{0, 0, 0, 0};
  int lock[4] = '{0, 0, 0, 0};
  int flg, hold, wide, pre, x, n, m, k, j;
  logic [9:0] ad[4] = '{10'h088, 10'h090, 10'h08C, 10'h094};
  timer_edge_capture u_timer_edge_capture (.CORE_CLK(clk), .SRST(srst),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
    .PSTRB(pst), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .EDGE_INPUT_A(ea), .EDGE_INPUT_B(eb), .IRQ_TICK(irq[0]),
    .IRQ_CAP0(irq[1]), .IRQ_CAP1(irq[2]), .IRQ_WRAP(irq[3]), .IRQ(irq[4]));
  edge_src u_edge_src (.clk(clk), .a(ea), .b(eb));
  // 25 ns clock
  initial forever #12.5 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; held until pready is seen at a rising edge
  task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= {24'h00_0000, d};
    pst <= w ? 4'hF : 4'h0;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rd(input logic [9:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  // counter write, low byte first
  task setc(input logic [15:0] v);
    bus(1'b1, 10'h080, v[7:0]);
    bus(1'b1, 10'h084, v[15:8]);
    x = v;
  endtask
  // counter read with a gap that lets the high byte move
  task rdc;
    rd(10'h080);
    n = r;
    repeat (30) @(negedge clk);
    rd(10'h084);
    n = {r[7:0], n[7:0]} - x;
  endtask
  // model: load one register unless held
  task upd(input int q, input int v);
    if (!(hold && lock[q])) begin
      cap[q] = v;
      flg |= 1 << q;
      lock[q] = hold;
    end
  endtask
  task ev(input int ch, input int fall);
    k = 2 * ch + fall;
    if (wide && ch == 0) begin
      upd(k, -1);
      upd(k + 2, x >> 8 & 255);
    end else if (!wide)
      upd(k, x >> pre & 255);
  endtask
  task hit(input int ch);
    u_edge_src.pulse(ch);
    ev(ch, 0);
    ev(ch, 1);
  endtask
  // read all captures; a read frees its hold
  task rdcap;
    for (k = 0; k < 4; k++) begin
      rd(ad[k]);
      if (cap[k] >= 0)
        cmp(r, cap[k]);
      else
        cmp(r < 8, 1'b1);
      lock[k] = 0;
    end
  endtask
  // main sequence
  initial begin
    void'($urandom(85046));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    for (j = 'hA8; j <= 'hB0; j += 4) begin
      rd(j[9:0]);
      cmp(r, 32'h0000_0000);
    end
    bus(1'b1, 10'h088, 8'hFF);
    rdcap();
    bus(1'b1, 10'h0A8, 8'hFF);
    rd(10'h0A8);
    cmp(r, 8'hF8);
    bus(1'b1, 10'h0AC, 8'hFF);
    rd(10'h0AC);
    cmp(r, 8'h0F);
    rd(10'h0FC);
    cmp(e, 1'b1);
    setc(($urandom & 16'h7E00) | 16'h00FE);
    rdc();
    cmp(n < 3, 1'b1);
    repeat (400) @(negedge clk);
    rdc();
    cmp(n >= 43 && n <= 46, 1'b1);
    for (m = 0; m < 8; m++) begin
      hold = m & 1;
      wide = m >> 1 & 1;
      pre = 3 + $urandom % 5;
      bus(1'b1, 10'h0A8, {hold[0], pre[2:0], wide[0], 3'h0});
      rdcap();
      bus(1'b1, 10'h0B0, 8'h0F);
      flg = 0;
      for (j = 0; j < 2; j++) begin
        setc($urandom & 16'h7F00);
        hit(m >> 2);
      end
      rd(10'h0B0);
      cmp(r, flg);
      cmp(irq[2:1], {|flg[3:2], |flg[1:0]});
      rdcap();
      hit(m >> 2);
      rdcap();
      bus(1'b1, 10'h0B0, 8'h01);
      flg &= 'hE;
      rd(10'h0B0);
      cmp(r, flg);
    end
    bus(1'b1, 10'h0B0, 8'h0F);
    bus(1'b1, 10'h0B8, 8'h00);
    rd(10'h0B4);
    cmp(r, 8'h0C);
    setc(16'hFFF0);
    repeat (200) @(negedge clk);
    cmp(irq[4], 1'b0);
    bus(1'b1, 10'h0B8, 8'h0F);
    repeat (2) @(negedge clk);
    cmp(irq[4:3], 2'b11);
    rd(10'h0B4);
    cmp(r, 8'h03);
    setc(16'h0FF0);
    n = 0;
    while (irq[0] !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    cmp(n >= 138 && n <= 168, 1'b1);
    rd(10'h0B4);
    cmp(r, 8'h01);
    repeat (3) @(negedge clk);
    cmp(irq[4], 1'b0);
    tally_and_finish();
  end
endmodule
